// ==== hw/gosm_regs.svh ====
// Register offsets, field positions, reset values and code points of the pin output mux.
// Assumes a 32-bit classic Wishbone slave; register offsets are word indices.
`ifndef GOSM_REGS_SVH
`define GOSM_REGS_SVH
`define GOSM_PIN5_IDX 8'h15
`define GOSM_PIN6_IDX 8'h16
`define GOSM_STATUS_IDX 8'h20
`define GOSM_CTRL_RESET 8'h00
`define GOSM_EN_BIT 0
`define GOSM_VAL_BIT 1
`define GOSM_SRC_LSB 2
`define GOSM_SRC_MSB 4
`define GOSM_SEL_LSB 5
`define GOSM_SEL_MSB 7
`define GOSM_SRC_STATUS 3'h4
`define GOSM_SRC_RSVD 3'h5
`define GOSM_SRC_TX0 3'h6
`define GOSM_SRC_TX1 3'h7
`define GOSM_RX_PORTS 4
`define GOSM_PINS 2
`endif

// ==== hw/gosm_pkg.sv ====
// Types shared by the pin output mux files.
// Assumes the register header is included by each user.
package gosm_pkg;
  // One pin control register, bit 7 down to bit 0.
  typedef struct packed {
    logic [2:0] sel;
    logic [2:0] src;
    logic value;
    logic enable;
  } gosm_ctrl_t;
  // Decoded source group of a pin.
  typedef enum {GOSM_G_RX, GOSM_G_STATUS, GOSM_G_TX, GOSM_G_RSVD} gosm_group_t;
endpackage

// ==== hw/gosm_pin_mux.sv ====
// One pin's source and selector multiplexer, purely combinational.
// Assumes all inputs are synchronous to the register clock.
`include "gosm_regs.svh"
module gosm_pin_mux
  import gosm_pkg::*;
(
  input wire gosm_ctrl_t ctrl_i, // Pin control register.
  input wire logic [15:0] rx_gpio_i, // Remote inputs, four per receive port.
  input wire logic [3:0] rx_lock_i, // Lock per receive port.
  input wire logic [3:0] rx_pass_i, // Pass per receive port.
  input wire logic [3:0] rx_fv_i, // Frame valid per receive port.
  input wire logic [3:0] rx_lv_i, // Line valid per receive port.
  input wire logic [3:0] rx_enabled_i, // Receive ports enabled.
  input wire logic frame_timing_pulse_i, // Frame sync signal.
  input wire logic [1:0] tx_pass_and_i, // Per transmit port AND of pass.
  input wire logic [1:0] tx_pass_or_i, // Per transmit port OR of pass.
  input wire logic [1:0] tx_fv_i, // Transmit frame in progress.
  input wire logic [1:0] tx_lv_i, // Transmit line in progress.
  input wire logic [1:0] tx_sync_i, // Multi-port data synchronized.
  input wire logic [1:0] tx_irq_i, // Transmit port interrupt.
  output logic level_o, // Selected pin level.
  output logic enable_o // Pin output enable.
);
  logic [1:0] rx_idx;
  logic tx_idx;
  logic [3:0] lk;
  logic [3:0] ps;

  // Only enabled ports take part; with no ports enabled the pass AND reads as one and the lock AND as zero.
  assign lk = rx_lock_i & rx_enabled_i;
  assign ps = rx_pass_i | ~rx_enabled_i;
  assign rx_idx = ctrl_i.src[1:0];
  assign tx_idx = ctrl_i.src[0];
  assign enable_o = ctrl_i.enable;

  // Group first, then the selector as that group defines it.
  always_comb begin
    level_o = 1'b0;
    if (ctrl_i.src[2] == 1'b0) begin
      case (ctrl_i.sel)
        3'h0, 3'h1, 3'h2, 3'h3: level_o = rx_gpio_i[{rx_idx, ctrl_i.sel[1:0]}];
        3'h4: level_o = rx_lock_i[rx_idx];
        3'h5: level_o = rx_pass_i[rx_idx];
        3'h6: level_o = rx_fv_i[rx_idx];
        3'h7: level_o = rx_lv_i[rx_idx];
        default: level_o = 1'b0;
      endcase
    end else if (ctrl_i.src == `GOSM_SRC_STATUS) begin
      case (ctrl_i.sel)
        3'h0: level_o = ctrl_i.value;
        3'h1: level_o = |lk;
        3'h2: level_o = (lk == rx_enabled_i) && (rx_enabled_i != 4'h0);
        3'h3: level_o = &ps;
        3'h4: level_o = frame_timing_pulse_i;
        default: level_o = 1'b0;
      endcase
    end else if (ctrl_i.src != `GOSM_SRC_RSVD) begin
      case (ctrl_i.sel)
        3'h0: level_o = tx_pass_and_i[tx_idx];
        3'h1: level_o = tx_pass_or_i[tx_idx];
        3'h2: level_o = tx_fv_i[tx_idx];
        3'h3: level_o = tx_lv_i[tx_idx];
        3'h4: level_o = tx_sync_i[tx_idx];
        3'h5: level_o = tx_irq_i[tx_idx];
        default: level_o = 1'b0;
      endcase
    end
  end
endmodule // gosm_pin_mux

// ==== hw/gosm_top.sv ====
// Output source multiplexer for two general-purpose pins, with a Wishbone register slave.
// Assumes every status input is synchronous to CLOCK_I; the pad turns enables into drive.
//
// Overview of operation
// - Source field bits 4:2 pick receive port 0-3, status, reserved, or transmit 0/1.
// - Selector bits 7:5 are decoded per source group to choose the pin signal.
// - Receive source, selector 0-3 forward that port's remote inputs 0-3.
// - Receive source, selector 4-7 give lock, pass, frame valid, line valid.
// - Status source, selector 0 drives the register's local value bit.
// - Status source, selector 1 ORs, selector 2 ANDs enabled ports' lock.
// - Status selector 3 ANDs enabled pass, 4 gives frame sync, 5-7 reserved.
// - Transmit source, selector 0 ANDs and selector 1 ORs selected pass status.
// - Transmit source, selector 2 is frame in progress, 3 line in progress.
// - Transmit selector 4 shows data synchronized, 5 the port interrupt, 6-7 reserved.
// - Bit 1 supplies the pin level when the local value is selected.
// - Bit 0 disables the pin output at 0 and enables it at 1.
// - Two identical control registers live at offsets 0x15 and 0x16.
//
// The implementer's own choice: the Wishbone register port.
`include "gosm_regs.svh"
module gosm_top
  import gosm_pkg::*;
(
  input wire logic CLOCK_I, // Register clock, 250 MHz.
  input wire logic RST_N_I, // Synchronous reset, active low.
  input wire logic WB_CYC_I, // Wishbone cycle.
  input wire logic WB_STB_I, // Wishbone strobe.
  input wire logic WB_WE_I, // Wishbone write enable.
  input wire logic [31:0] WB_ADR_I, // Wishbone byte address.
  input wire logic [3:0] WB_SEL_I, // Wishbone byte enables.
  input wire logic [31:0] WB_DAT_I, // Wishbone write data.
  output logic [31:0] WB_DAT_O, // Wishbone read data.
  output logic WB_ACK_O, // Wishbone acknowledge.
  output logic WB_ERR_O, // Wishbone error for unmapped addresses.
  input wire logic [15:0] RX_GPIO_I, // Remote inputs, port p bit b at 4p+b.
  input wire logic [3:0] RX_LOCK_I, // Receive lock per port.
  input wire logic [3:0] RX_PASS_I, // Receive pass per port.
  input wire logic [3:0] RX_FV_I, // Receive frame valid per port.
  input wire logic [3:0] RX_LV_I, // Receive line valid per port.
  input wire logic [3:0] RX_ENABLED_I, // Receive ports enabled.
  input wire logic [3:0] TX0_RX_SELECT_I, // Receive ports mapped to transmit 0.
  input wire logic [3:0] TX1_RX_SELECT_I, // Receive ports mapped to transmit 1.
  input wire logic FRAME_TIMING_PULSE_I, // Frame sync signal.
  input wire logic [1:0] TX_FV_I, // Transmit frame in progress.
  input wire logic [1:0] TX_LV_I, // Transmit line in progress.
  input wire logic [1:0] TX_SYNC_I, // Multi-port data synchronized.
  input wire logic [1:0] TX_IRQ_I, // Transmit port interrupt.
  output logic [1:0] PIN_O, // Pin levels, bit 0 is pin 5, bit 1 is pin 6.
  output logic [1:0] PIN_OE_O // Pin output enables, high while driven.
);
  // All state of the block.
  typedef struct packed {
    gosm_ctrl_t [1:0] ctrl;
    logic ack;
    logic err;
    logic [31:0] rdata;
    logic [1:0] pin;
    logic [1:0] pin_oe;
  } gosm_state_t;

  gosm_state_t st;
  gosm_state_t next_st;
  logic [1:0] mux_level;
  logic [1:0] mux_en;
  logic [1:0] tx_and;
  logic [1:0] tx_or;
  logic [7:0] word_idx;
  logic req;

  // Returns which control register an index addresses, or 2 for none.
  function automatic logic [1:0] gosm_decode(input logic [7:0] idx);
    if (idx == `GOSM_PIN5_IDX) begin
      gosm_decode = 2'd0;
    end else if (idx == `GOSM_PIN6_IDX) begin
      gosm_decode = 2'd1;
    end else begin
      gosm_decode = 2'd2;
    end
  endfunction

  // Pass status of receive ports mapped to each transmit port; an empty map gives AND 1, OR 0.
  assign tx_and[0] = &(RX_PASS_I | ~TX0_RX_SELECT_I);
  assign tx_and[1] = &(RX_PASS_I | ~TX1_RX_SELECT_I);
  assign tx_or[0] = |(RX_PASS_I & TX0_RX_SELECT_I);
  assign tx_or[1] = |(RX_PASS_I & TX1_RX_SELECT_I);

  // One multiplexer per pin.
  genvar g;
  generate
    for (g = 0; g < `GOSM_PINS; g++) begin : g_pin
      gosm_pin_mux u_mux (
        .ctrl_i(st.ctrl[g]),
        .rx_gpio_i(RX_GPIO_I),
        .rx_lock_i(RX_LOCK_I),
        .rx_pass_i(RX_PASS_I),
        .rx_fv_i(RX_FV_I),
        .rx_lv_i(RX_LV_I),
        .rx_enabled_i(RX_ENABLED_I),
        .frame_timing_pulse_i(FRAME_TIMING_PULSE_I),
        .tx_pass_and_i(tx_and),
        .tx_pass_or_i(tx_or),
        .tx_fv_i(TX_FV_I),
        .tx_lv_i(TX_LV_I),
        .tx_sync_i(TX_SYNC_I),
        .tx_irq_i(TX_IRQ_I),
        .level_o(mux_level[g]),
        .enable_o(mux_en[g])
      );
    end
  endgenerate

  // Word index from the byte address; upper address bits must be zero to hit.
  assign word_idx = WB_ADR_I[9:2];
  assign req = WB_CYC_I && WB_STB_I && !st.ack && !st.err;

  // Next state: bus answer in one cycle, then a one-cycle gap before the next answer.
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;
    next_st.pin = mux_level;
    // Disabled pins are forced low so the released wire carries no stale level.
    for (int i = 0; i < `GOSM_PINS; i++) begin
      if (!mux_en[i]) begin
        next_st.pin[i] = 1'b0;
      end
    end
    next_st.pin_oe = mux_en;
    if (req) begin
      if (WB_ADR_I[31:10] != 22'h00_0000 || WB_ADR_I[1:0] != 2'h0) begin
        next_st.err = 1'b1;
      end else if (word_idx == `GOSM_STATUS_IDX) begin
        // Read-only view of the live pin state; writes are accepted and dropped.
        next_st.ack = 1'b1;
        next_st.rdata = {28'h000_0000, st.pin_oe, st.pin};
      end else if (gosm_decode(word_idx) != 2'd2) begin
        next_st.ack = 1'b1;
        next_st.rdata = {24'h00_0000, st.ctrl[gosm_decode(word_idx)]};
        if (WB_WE_I && WB_SEL_I[0]) begin
          next_st.ctrl[gosm_decode(word_idx)] = WB_DAT_I[7:0];
        end
      end else begin
        next_st.err = 1'b1;
      end
    end
  end

  // Single register stage for the whole block.
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      st <= '0;
      st.ctrl[0] <= `GOSM_CTRL_RESET;
      st.ctrl[1] <= `GOSM_CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign WB_ACK_O = st.ack;
  assign WB_ERR_O = st.err;
  assign WB_DAT_O = st.rdata;
  assign PIN_O = st.pin;
  assign PIN_OE_O = st.pin_oe;
endmodule // gosm_top

// ==== tb/gosm_top_sva.sv ====
// Checker for the pin output mux: bus answer timing and pin drive relations.
// Assumes it is bound to gosm_top and sees only that module's ports.
module gosm_top_sva (
  input wire logic CLOCK_I, // Register clock.
  input wire logic RST_N_I, // Synchronous reset, active low.
  input wire logic WB_CYC_I, // Bus cycle.
  input wire logic WB_STB_I, // Bus strobe.
  input wire logic WB_WE_I, // Bus write enable.
  input wire logic [31:0] WB_ADR_I, // Bus byte address.
  input wire logic [31:0] WB_DAT_O, // Read data.
  input wire logic WB_ACK_O, // Acknowledge.
  input wire logic WB_ERR_O, // Error answer.
  input wire logic [1:0] PIN_O, // Pin levels.
  input wire logic [1:0] PIN_OE_O // Pin enables.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hit; // Aligned request to one of the three mapped words.
  // Misaligned or unmapped requests must get an error, never a silent ack.
  assign hit = WB_ADR_I[31:10] == 22'h0 && WB_ADR_I[1:0] == 2'h0 &&
    (WB_ADR_I[9:2] == 8'h15 || WB_ADR_I[9:2] == 8'h16 || WB_ADR_I[9:2] == 8'h20);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  endsequence
  AST_MAP: assert property (s_req ##0 hit |=> WB_ACK_O && !WB_ERR_O)
    else $error("mapped request not acked");
  AST_UNMAP: assert property (s_req ##0 !hit |=> WB_ERR_O && !WB_ACK_O)
    else $error("unmapped request not refused");
  AST_PULSE: assert property (WB_ACK_O || WB_ERR_O |=> !WB_ACK_O && !WB_ERR_O)
    else $error("answer longer than one cycle");
  AST_CAUSE: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without request");
  AST_HIGH: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_RST: assert property ($rose(RST_N_I) |-> PIN_OE_O == 2'h0 && PIN_O == 2'h0)
    else $error("pins driven after reset");
  AST_OFF: assert property ((PIN_O & ~PIN_OE_O) == 2'h0)
    else $error("disabled pin not low");
  AST_HOLD: assert property (!$past(WB_CYC_I && WB_STB_I && WB_WE_I) |-> $stable(PIN_OE_O))
    else $error("enable moved without write");
endmodule // gosm_top_sva

// ==== tb/gosm_board.sv ====
// Board model watching the two pins.
// Assumes no pull resistor, so a released pad holds no defined level.
module gosm_board (
  input wire logic clk_i, // Register clock.
  input wire logic [1:0] pin_i, // Driven levels.
  input wire logic [1:0] oe_i, // Drive enables.
  output logic [1:0] pad_o // Pad levels seen by the board.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] last = 2'h0;
  // A released pad shows the inverse of the last driven level, never a stale valid one.
  always_ff @(posedge clk_i) begin
    last <= (oe_i & pin_i) | (~oe_i & last);
  end
  assign pad_o = (oe_i & pin_i) | (~oe_i & ~last);
endmodule // gosm_board

// ==== tb/gosm_top_tb.sv ====
// Testbench of the pin output mux: register access and every control code on both pins.
// Assumes one ack or err pulse answers each bus request.
module gosm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, cyc, stb, we, ack, err, e;
  logic [3:0] sel, wsel;
  logic [31:0] adr, dat, rdat, q;
  logic [52:0] s;
  logic [1:0] pin, oe, pad;
  int fails, checks_done;
  gosm_top dut (.CLOCK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .WB_ERR_O(err), .RX_GPIO_I(s[15:0]), .RX_LOCK_I(s[19:16]),
    .RX_PASS_I(s[23:20]), .RX_FV_I(s[27:24]), .RX_LV_I(s[31:28]),
    .RX_ENABLED_I(s[35:32]), .TX0_RX_SELECT_I(s[39:36]), .TX1_RX_SELECT_I(s[43:40]),
    .FRAME_TIMING_PULSE_I(s[44]), .TX_FV_I(s[46:45]), .TX_LV_I(s[48:47]),
    .TX_SYNC_I(s[50:49]), .TX_IRQ_I(s[52:51]), .PIN_O(pin), .PIN_OE_O(oe));
  gosm_board board (.clk_i(clk), .pin_i(pin), .oe_i(oe), .pad_o(pad));
  // Expected {enable, level} of one pin, written from the field decode alone.
  function automatic logic [1:0] exp_pin(logic [7:0] c, logic [52:0] x);
    logic [2:0] sr, se;
    logic [3:0] en, lk, ps, m;
    logic v;
    sr = c[4:2];
    se = c[7:5];
    lk = x[19:16];
    ps = x[23:20];
    en = x[35:32];
    m = sr[0] ? x[43:40] : x[39:36];
    v = 1'b0;
    if (sr < 4) v = se < 4 ? x[4 * sr + se] : x[16 + 4 * (se - 4) + sr];
    else if (sr == 4) v = se == 0 ? c[1] : se == 1 ? |(lk & en) :
      se == 2 ? en != 0 && (lk & en) == en : se == 3 ? (ps & en) == en : se == 4 && x[44];
    else if (sr > 5) v = se == 0 ? (ps & m) == m : se == 1 ? |(ps & m) :
      se > 1 && se < 6 && x[45 + 2 * (se - 2) + sr[0]];
    return c[0] ? {1'b1, v} : 2'h0;
  endfunction
  task automatic results();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One classic cycle; the request stands until the answer is sampled.
  task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= wsel;
    adr <= {24'h0, a};
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    if (ack !== 1'b1 && err !== 1'b1) begin
      fails++;
      results();
    end
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic t_defaults();
    wb(8'h54, 1'b0, 8'h0);
    chk(q, 32'h0);
    wb(8'h58, 1'b0, 8'h0);
    chk(q, 32'h0);
    chk(32'(oe), 32'h0);
    wb(8'h5C, 1'b0, 8'h0);
    chk(32'(e), 32'h1);
    wb(8'h55, 1'b1, 8'hFF);
    chk(32'(e), 32'h1);
    wb(8'h80, 1'b0, 8'h0);
    chk(q, 32'h0);
    // A write without the low byte lane enabled must leave the register alone.
    wsel = 4'h0;
    wb(8'h54, 1'b1, 8'hFF);
    wsel = 4'h1;
    wb(8'h54, 1'b0, 8'h0);
    chk(q, 32'h0);
  endtask
  // Every control byte on pin 5 with its inverse on pin 6, over varied inputs.
  task automatic t_codes();
    logic [52:0] b, r;
    logic [1:0] e5, e6;
    b = 53'h1A_5C3C_96E1_F0F5;
    for (int i = 0; i < 6; i++) begin
      r = (b << (9 * i)) | (b >> (53 - 9 * i));
      s <= i[0] ? ~r : r;
      for (int c = 0; c < 256; c++) begin
        wb(8'h54, 1'b1, c[7:0]);
        wb(8'h58, 1'b1, ~c[7:0]);
        @(negedge clk);
        chk(32'({oe[0], pad[0] & oe[0]}), 32'(exp_pin(c[7:0], s)));
        chk(32'({oe[1], pad[1] & oe[1]}), 32'(exp_pin(~c[7:0], s)));
      end
      wb(8'h54, 1'b0, 8'h0);
      chk(q, 32'h0000_00FF);
    end
    // The live pin view must match the last pair of codes written.
    e5 = exp_pin(8'hFF, s);
    e6 = exp_pin(8'h00, s);
    wb(8'h80, 1'b0, 8'h0);
    chk(q, 32'({e6[1], e5[1], e6[0], e5[0]}));
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Reset, check defaults, sweep the codes, then reset in mid-run.
  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 32'h0;
    sel = 4'h1;
    wsel = 4'h1;
    dat = 32'h0;
    s = '0;
    fails = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    t_codes();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    results();
  end
endmodule // gosm_top_tb
bind gosm_top gosm_top_sva sva (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O), .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O));
